// ===== rtl/pce_top.sv
// Purpose: change-masked event trigger and process image of a field bus coupler
// Assumes: payload mapping and limit/delta settings are made outside this block
// Notes: one transmit object is examined per clock, round robin
`timescale 1ns/1ps
`include "pce_params.svh"

// ****************************************
// request queue
// ****************************************
// queue of send requests; upstream stalls while it is full
module pce_fifo #(
  parameter int WIDTH = 68,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } pce_fifo_st_s;
  pce_fifo_st_s st, next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  // refuse depths the wrap-bit pointers cannot serve
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end

  // full when pointers differ only in the wrap bit
  assign in_ready = !((st.wr[AW] != st.rd[AW]) && (st.wr[AW-1:0] == st.rd[AW-1:0]));
  assign out_valid = (st.wr != st.rd);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[st.rd[AW-1:0]];

  // pointer update
  always_comb begin
    next_st = st;
    if (push) next_st.wr = st.wr + 1'b1;
    if (pop) next_st.rd = st.rd + 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge clk_sys) begin
    if (push) mem[st.wr[AW-1:0]] <= in_data;
  end
endmodule : pce_fifo

// ****************************************
// top
// ****************************************
// Overview of operation
// - with default masks any payload change of an event object sends it, except an analog one while the analog gate is clear
// - payload bits with cleared mask bits trigger no send unless limit or delta watch overrides the mask
// - masking applies to every existing transmit object
// - two 32-bit masks per object, bytes 0-3 and 4-7; sub 0 counts
// - mask bits of bytes beyond the object's length are ignored
// - masks only affect objects with transmission type 254 or 255
// - masks are never stored; they return to all ones after reset
// - masks writable while running, effective from the next compare of the object
// - analog objects ignore the mask while limit or delta watch is on
// - up to 254 read-only 8-bit input blocks, sub 0 gives count
// - up to 254 writable 8-bit output blocks, default zero, sub 0 count
// - analog channels are 16-bit left-aligned words
// - analog objects raise no events until the global analog gate is set
// - nonzero upper limit exceeded with gate set sends the object
module pce_top #(
  parameter int N_TX = `PCE_MAX_TX,
  parameter int N_DI = 8,
  parameter int N_DO = 8,
  parameter int N_AI = 4,
  parameter int N_AO = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [N_DI-1:0][7:0] dig_in,
  output logic [N_DO-1:0][7:0] dig_out,
  input wire logic [N_AI-1:0][15:0] ana_in,
  output logic [N_AO-1:0][15:0] ana_out,
  input wire logic [N_TX-1:0][63:0] pdo_data,
  input wire logic [N_TX-1:0][3:0] pdo_len,
  input wire logic [N_TX-1:0][7:0] pdo_ttype,
  input wire logic [N_TX-1:0] pdo_is_analog,
  input wire logic [N_TX-1:0][63:0] pdo_upper_limit,
  input wire logic [N_TX-1:0] pdo_lo_delta_on,
  input wire logic od_valid,
  input wire pce_pkg::pce_od_req_s od_req,
  output logic od_ack,
  output pce_pkg::pce_od_rsp_s od_rsp,
  output logic tx_valid,
  input wire logic tx_ready,
  output pce_pkg::pce_tx_s tx_out
);
  localparam int PW = $clog2(N_TX);

  typedef struct packed {
    logic [2*N_TX-1:0][31:0] mask;
    logic [N_TX-1:0][63:0] last;
    logic [N_TX-1:0] over;
    logic [N_DO-1:0][7:0] dout;
    logic [N_AO-1:0][15:0] aout;
    logic gate;
    logic [PW-1:0] scan;
    logic ack;
    pce_pkg::pce_od_rsp_s rsp;
    logic [2:0][N_DI-1:0][7:0] dsync;
    logic [N_DI-1:0][7:0] dstable;
  } pce_st_s;

  pce_st_s st, next_st;
  logic [1:0] rst_pipe;
  logic rst_int_n;
  logic q_valid, q_ready;
  pce_pkg::pce_tx_s q_data;

  // elaboration checks; the round robin scan needs a power of two
  if (N_TX < 2 || N_TX > `PCE_MAX_TX || (1 << PW) != N_TX) begin : g_bad_tx
    $error("bad N_TX");
  end
  if (N_DI < 1 || N_DI > `PCE_MAX_BLOCKS || N_DO < 1 || N_DO > `PCE_MAX_BLOCKS) begin : g_bad_dig
    $error("bad digital block count");
  end
  if (N_AI < 1 || N_AI > `PCE_MAX_BLOCKS || N_AO < 1 || N_AO > `PCE_MAX_BLOCKS) begin : g_bad_ana
    $error("bad analog channel count");
  end

  // byte enable of a payload of len bytes, one byte at a time
  function automatic logic [63:0] len_mask(input logic [3:0] len);
    logic [63:0] m;
    m = '0;
    for (int k = 0; k < 8; k++) begin
      if (4'(k) < len) m[8*k +: 8] = 8'hff;
    end
    return m;
  endfunction : len_mask

  // true when a subindex selects entry 1..n
  function automatic logic sub_ok(input logic [7:0] sub, input int n);
    return (sub != 8'h00) && (32'(sub) <= n);
  endfunction : sub_ok

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_int_n = rst_pipe[1];

  // next state: input sync, object scan, dictionary access
  always_comb begin
    logic [63:0] cur, emask, diff;
    logic is_evt, gated, over_now, lim_on;
    logic [PW:0] mi;
    next_st = st;
    cur = pdo_data[st.scan];
    emask = '0;
    diff = '0;
    over_now = 1'b0;
    lim_on = 1'b0;
    mi = '0;
    is_evt = 1'b0;
    gated = 1'b0;
    next_st.ack = 1'b0;
    // three-stage input sync; a change counts once stages two and three agree
    next_st.dsync = {st.dsync[1:0], dig_in};
    if (st.dsync[1] == st.dsync[2]) next_st.dstable = st.dsync[2];

    emask = {st.mask[2*st.scan+1], st.mask[2*st.scan]};
    emask = emask & len_mask(pdo_len[st.scan]);
    for (int w = 0; w < 4; w++) begin
      if (pdo_upper_limit[st.scan][16*w +: 16] != 16'h0000) begin
        lim_on = 1'b1;
        if (cur[16*w +: 16] > pdo_upper_limit[st.scan][16*w +: 16]) over_now = 1'b1;
      end
    end
    // limit or delta watch overrides the mask
    if (pdo_is_analog[st.scan] && (lim_on || pdo_lo_delta_on[st.scan])) begin
      emask = len_mask(pdo_len[st.scan]);
    end
    diff = (cur ^ st.last[st.scan]) & emask;
    is_evt = (pdo_ttype[st.scan] == `PCE_TTYPE_EVT_MFR) ||
             (pdo_ttype[st.scan] == `PCE_TTYPE_EVT_PROF);
    gated = pdo_is_analog[st.scan] && !st.gate;
    q_valid = is_evt && !gated && ((diff != '0) || (pdo_is_analog[st.scan] &&
              over_now && !st.over[st.scan]));
    q_data.pdo = 4'(st.scan);
    q_data.data = cur;
    // a full queue holds the scan on this object until one entry is taken
    if (!q_valid || q_ready) begin
      next_st.scan = st.scan + 1'b1;
      next_st.over[st.scan] = over_now;
      if (q_valid) next_st.last[st.scan] = cur;
    end

    // dictionary access, answered one cycle later
    if (od_valid) begin
      next_st.ack = 1'b1;
      next_st.rsp = '0;
      if (od_req.index == `PCE_IDX_DIG_IN) begin
        if (od_req.wr) next_st.rsp.err = 1'b1;
        else if (od_req.sub == 8'h00) next_st.rsp.rdata = 32'(N_DI);
        else if (sub_ok(od_req.sub, N_DI)) begin
          next_st.rsp.rdata = 32'(st.dstable[od_req.sub - 8'h01]);
        end else next_st.rsp.err = 1'b1;
      end else if (od_req.index == `PCE_IDX_MASKS) begin
        mi = (PW+1)'(od_req.sub - 8'h01);
        if (od_req.sub == 8'h00) begin
          if (od_req.wr) next_st.rsp.err = 1'b1;
          else next_st.rsp.rdata = 32'(2 * N_TX);
        end else if (sub_ok(od_req.sub, 2 * N_TX)) begin
          // runtime mask write, used from the next compare
          if (od_req.wr) next_st.mask[mi] = od_req.wdata;
          else next_st.rsp.rdata = st.mask[mi];
        end else next_st.rsp.err = 1'b1;
      end else if (od_req.index == `PCE_IDX_DIG_OUT) begin
        if (od_req.sub == 8'h00) begin
          if (od_req.wr) next_st.rsp.err = 1'b1;
          else next_st.rsp.rdata = 32'(N_DO);
        end else if (sub_ok(od_req.sub, N_DO)) begin
          if (od_req.wr) next_st.dout[od_req.sub - 8'h01] = od_req.wdata[7:0];
          else next_st.rsp.rdata = 32'(st.dout[od_req.sub - 8'h01]);
        end else next_st.rsp.err = 1'b1;
      end else if (od_req.index == `PCE_IDX_ANA_IN) begin
        if (od_req.wr) next_st.rsp.err = 1'b1;
        else if (od_req.sub == 8'h00) next_st.rsp.rdata = 32'(N_AI);
        else if (sub_ok(od_req.sub, N_AI)) begin
          next_st.rsp.rdata = 32'(ana_in[od_req.sub - 8'h01]);
        end else next_st.rsp.err = 1'b1;
      end else if (od_req.index == `PCE_IDX_ANA_OUT) begin
        if (od_req.sub == 8'h00) begin
          if (od_req.wr) next_st.rsp.err = 1'b1;
          else next_st.rsp.rdata = 32'(N_AO);
        end else if (sub_ok(od_req.sub, N_AO)) begin
          if (od_req.wr) next_st.aout[od_req.sub - 8'h01] = od_req.wdata[15:0];
          else next_st.rsp.rdata = 32'(st.aout[od_req.sub - 8'h01]);
        end else next_st.rsp.err = 1'b1;
      end else if (od_req.index == `PCE_IDX_ANA_GATE) begin
        if (od_req.sub != 8'h00) next_st.rsp.err = 1'b1;
        else if (od_req.wr) next_st.gate = od_req.wdata[0];
        else next_st.rsp.rdata = 32'(st.gate);
      end else begin
        next_st.rsp.err = 1'b1;
      end
    end
  end

  // masks restart at all ones, nothing kept across reset
  always_ff @(posedge clk_sys or negedge rst_int_n) begin
    if (!rst_int_n) begin
      st <= '0;
      st.mask <= {(2*N_TX){`PCE_MASK_RESET}};
      st.dout <= {N_DO{`PCE_DIG_RESET}};
      st.aout <= {N_AO{`PCE_ANA_RESET}};
      st.gate <= `PCE_GATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign dig_out = st.dout;
  assign ana_out = st.aout;
  assign od_ack = st.ack;
  assign od_rsp = st.rsp;

  // send requests queue here; the link side drains at its own pace
  pce_fifo #(
    .WIDTH($bits(pce_pkg::pce_tx_s)),
    .DEPTH(16)
  ) u_pce_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_int_n),
    .in_valid(q_valid),
    .in_ready(q_ready),
    .in_data(q_data),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_out)
  );
endmodule : pce_top

// ===== inc/pce_params.svh
// Purpose: offsets, field positions, reset values and counts for the change-event block
// Assumes: included by the package user files by bare name
// Notes: object indices are the dictionary addresses used on the access port
`ifndef PCE_PARAMS_SVH
`define PCE_PARAMS_SVH

// ****************************************
// dictionary indices
// ****************************************
`define PCE_IDX_DIG_IN 16'h6000
`define PCE_IDX_MASKS 16'h6126
`define PCE_IDX_DIG_OUT 16'h6200
`define PCE_IDX_ANA_IN 16'h6401
`define PCE_IDX_ANA_OUT 16'h6411
`define PCE_IDX_ANA_GATE 16'h6423

// ****************************************
// reset values and codes
// ****************************************
`define PCE_MASK_RESET 32'hffffffff
`define PCE_DIG_RESET 8'h00
`define PCE_ANA_RESET 16'h0000
`define PCE_GATE_RESET 1'b0
`define PCE_TTYPE_EVT_MFR 8'hfe
`define PCE_TTYPE_EVT_PROF 8'hff
`define PCE_PDO_BYTES 4'h8
`define PCE_MAX_BLOCKS 254
`define PCE_MAX_TX 16

`endif

// ===== inc/pce_pkg.sv
// Purpose: shared types of the change-event block
// Assumes: widths fixed for up to 16 transmit objects of 8 bytes
// Notes: constants live in pce_params.svh
package pce_pkg;

  // ****************************************
  // access port request and answer
  // ****************************************
  typedef struct packed {
    logic wr;
    logic [15:0] index;
    logic [7:0] sub;
    logic [31:0] wdata;
  } pce_od_req_s;

  typedef struct packed {
    logic err;
    logic [31:0] rdata;
  } pce_od_rsp_s;

  // ****************************************
  // one queued transmit request
  // ****************************************
  typedef struct packed {
    logic [3:0] pdo;
    logic [63:0] data;
  } pce_tx_s;

endpackage : pce_pkg

// ===== dv/pce_top_properties.sv
// Purpose: port-level checks of the change-event block
// Assumes: each access is answered one cycle after its request
// Notes: bound into every pce_top at the foot of this file
`timescale 1ns/1ps
`include "pce_params.svh"
module pce_top_properties #(
  parameter int N_TX = 16,
  parameter int N_DI = 8,
  parameter int N_DO = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic od_valid,
  input wire pce_pkg::pce_od_req_s od_req,
  input wire logic od_ack,
  input wire pce_pkg::pce_od_rsp_s od_rsp,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire pce_pkg::pce_tx_s tx_out,
  input wire logic [N_DO-1:0][7:0] dig_out
);
  logic [7:0] out_val;
  logic wr_out_now;
  // only a write to the first block moves the tracked value
  assign wr_out_now = od_valid && od_req.wr && od_req.index == `PCE_IDX_DIG_OUT &&
                      od_req.sub == 8'h01;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // ****
  // access port and send queue
  // ****
  sequence rd_s(idx, sb);
    od_valid && !od_req.wr && od_req.index == idx && od_req.sub == sb;
  endsequence
  sequence wr_out_s;
    od_valid && od_req.wr && od_req.index == `PCE_IDX_DIG_OUT && od_req.sub == 8'h01;
  endsequence
  // last byte written to the first output block
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_val <= 8'h00;
    end else if (wr_out_now) begin
      out_val <= od_req.wdata[7:0];
    end
  end
  ack_after_req_a: assert property (od_valid |=> od_ack)
    else $error("request not answered one cycle later");
  ack_needs_req_a: assert property (!od_valid |=> !od_ack)
    else $error("answer without a request");
  rsp_holds_a: assert property (!od_ack |-> $stable(od_rsp))
    else $error("answer changed between acknowledges");
  err_zero_data_a: assert property (od_ack && od_rsp.err |-> od_rsp.rdata == 32'h0)
    else $error("refused access returned data");
  mask_count_a: assert property (rd_s(`PCE_IDX_MASKS, 8'h00) |=> !od_rsp.err && od_rsp.rdata == 2 * N_TX)
    else $error("mask count wrong");
  mask_range_a: assert property (od_valid && od_req.index == `PCE_IDX_MASKS && od_req.sub > 2 * N_TX |=> od_rsp.err)
    else $error("mask beyond range accepted");
  input_count_a: assert property (rd_s(`PCE_IDX_DIG_IN, 8'h00) |=> od_rsp.rdata == N_DI)
    else $error("input block count wrong");
  input_ro_a: assert property (od_valid && od_req.wr && od_req.index == `PCE_IDX_DIG_IN |=> od_rsp.err)
    else $error("write to input block accepted");
  output_write_a: assert property (wr_out_s |=> ##[0:1] dig_out[0] == out_val)
    else $error("output block not driven with written value");
  tx_stands_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_out))
    else $error("queued send dropped or changed while stalled");
endmodule : pce_top_properties

bind pce_top pce_top_properties #(.N_TX(N_TX), .N_DI(N_DI), .N_DO(N_DO)) u_pce_top_properties (
  .clk_sys(clk_sys), .rst_n(rst_n), .od_valid(od_valid), .od_req(od_req), .od_ack(od_ack),
  .od_rsp(od_rsp), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_out(tx_out), .dig_out(dig_out));

// ===== dv/pce_master_model.sv
// Purpose: bus master side that takes queued process objects
// Assumes: one object per cycle when not stalled
// Notes: stall models a busy bus; taken objects wait in got
`timescale 1ns/1ps
module pce_master_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire pce_pkg::pce_tx_s tx_out
);
  pce_pkg::pce_tx_s got[$];
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_ready <= 1'b0;
    end else begin
      if (tx_valid && tx_ready) begin
        got.push_back(tx_out);
      end
      tx_ready <= !stall;
    end
  end
endmodule : pce_master_model

// ===== dv/pce_top_bench.sv
// Purpose: self-checking bench of the change-event block
// Assumes: two transmit objects, object 1 analog
// Notes: payloads start at zero so no send follows reset
`timescale 1ns/1ps
`include "pce_params.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module pce_top_bench;
  logic clk_sys = 1'b0, rst_n = 1'b0, od_valid = 1'b0, stall = 1'b0;
  logic od_ack, tx_valid, tx_ready;
  logic [1:0][7:0] dig_in = 16'h5ac3, dig_out;
  logic [1:0][15:0] ana_in = 32'h1234_8000, ana_out;
  logic [1:0][63:0] pdo_data = '0, pdo_upper_limit = '0;
  logic [1:0][3:0] pdo_len = 8'h88;
  logic [1:0][7:0] pdo_ttype = 16'hffff;
  logic [1:0] pdo_is_analog = 2'h2, pdo_lo_delta_on = 2'h0;
  pce_pkg::pce_od_req_s od_req = '0;
  pce_pkg::pce_od_rsp_s od_rsp;
  pce_pkg::pce_tx_s tx_out;
  int n_mismatch = 0;
  int tests_run = 0;
  pce_top #(.N_TX(2), .N_DI(2), .N_DO(2), .N_AI(2), .N_AO(2)) u_pce_top (.clk_sys, .rst_n,
    .dig_in, .dig_out, .ana_in, .ana_out, .pdo_data, .pdo_len, .pdo_ttype, .pdo_is_analog,
    .pdo_upper_limit, .pdo_lo_delta_on, .od_valid, .od_req, .od_ack, .od_rsp, .tx_valid,
    .tx_ready, .tx_out);
  pce_master_model u_pce_master_model (.clk_sys, .rst_n, .stall, .tx_valid, .tx_ready, .tx_out);
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  // ****
  // shared tasks
  // ****
  task automatic report_and_stop;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  // one access; write answers carry no data worth comparing
  task automatic od(input logic w, input logic [15:0] ix, input logic [7:0] sb,
      input logic [31:0] wd, input logic [32:0] exp);
    @(posedge clk_sys);
    od_valid <= 1'b1;
    od_req <= '{w, ix, sb, wd};
    @(posedge clk_sys);
    od_valid <= 1'b0;
    #1;
    `CHK(od_ack, 1'b1)
    `CHK(({od_rsp.err, w ? 32'h0 : od_rsp.rdata}), exp)
  endtask : od
  task automatic put(input int p, input logic [63:0] d);
    @(posedge clk_sys);
    pdo_data[p] <= d;
  endtask : put
  task automatic expect_tx(input logic [67:0] exp);
    int i = 0;
    pce_pkg::pce_tx_s g;
    while (u_pce_master_model.got.size() == 0 && i < 64) begin
      i++;
      @(posedge clk_sys);
    end
    if (u_pce_master_model.got.size() == 0) begin
      n_mismatch++;
      report_and_stop();
    end
    g = u_pce_master_model.got.pop_front();
    `CHK(g, exp)
  endtask : expect_tx
  task automatic expect_none;
    repeat (12) @(posedge clk_sys);
    `CHK(u_pce_master_model.got.size(), 0)
  endtask : expect_none
  // ****
  // scenarios
  // ****
  task automatic t_regs;
    od(0, `PCE_IDX_MASKS, 8'h00, 0, 33'h4);
    od(0, `PCE_IDX_MASKS, 8'h04, 0, 33'hffff_ffff);
    od(0, `PCE_IDX_MASKS, 8'h05, 0, 33'h1_0000_0000);
    od(1, `PCE_IDX_MASKS, 8'h00, 0, 33'h1_0000_0000);
    od(0, `PCE_IDX_DIG_IN, 8'h00, 0, 33'h2);
    od(0, `PCE_IDX_DIG_IN, 8'h02, 0, 33'h5a);
    od(1, `PCE_IDX_DIG_IN, 8'h01, 0, 33'h1_0000_0000);
    od(0, `PCE_IDX_DIG_OUT, 8'h02, 0, 33'h0);
    od(1, `PCE_IDX_DIG_OUT, 8'h01, 32'h3c, 33'h0);
    od(0, `PCE_IDX_ANA_IN, 8'h02, 0, 33'h1234);
    od(1, `PCE_IDX_ANA_OUT, 8'h01, 32'hbeef, 33'h0);
    od(0, `PCE_IDX_ANA_OUT, 8'h01, 0, 33'hbeef);
    od(1, `PCE_IDX_ANA_OUT, 8'h00, 0, 33'h1_0000_0000);
    od(0, 16'h6001, 8'h00, 0, 33'h1_0000_0000);
    `CHK(dig_out[0], 8'h3c)
    `CHK(ana_out[0], 16'hbeef)
  endtask : t_regs
  task automatic t_mask;
    put(0, 64'h11);
    expect_tx({4'h0, 64'h11});
    od(1, `PCE_IDX_MASKS, 8'h01, 32'hff00, 33'h0);
    od(1, `PCE_IDX_MASKS, 8'h02, 32'h0, 33'h0);
    put(0, 64'h9900_0000_0000_0012);
    expect_none();
    put(0, 64'h9900_0000_0000_0112);
    expect_tx({4'h0, 64'h9900_0000_0000_0112});
    put(0, 64'h112);
    expect_none();
    od(1, `PCE_IDX_MASKS, 8'h02, 32'hffff_ffff, 33'h0);
    expect_tx({4'h0, 64'h112});
    od(1, `PCE_IDX_MASKS, 8'h01, 32'hffff_ffff, 33'h0);
    @(posedge clk_sys);
    pdo_len[0] <= 4'h2;
    put(0, 64'hff_0000_0112);
    expect_none();
    put(0, 64'hff_0000_0212);
    expect_tx({4'h0, 64'hff_0000_0212});
  endtask : t_mask
  task automatic t_ttype;
    logic [7:0] tt [4] = '{8'h00, 8'h01, 8'hf0, 8'hfd};
    pdo_len[0] <= 4'h8;
    for (int i = 0; i < 4; i++) begin
      pdo_ttype[0] <= tt[i];
      put(0, 64'h300 + i);
      expect_none();
    end
    pdo_ttype[0] <= 8'hfe;
    expect_tx({4'h0, 64'h303});
  endtask : t_ttype
  task automatic t_analog;
    put(1, 64'h100);
    expect_none();
    od(1, `PCE_IDX_MASKS, 8'h03, 0, 33'h0);
    od(1, `PCE_IDX_MASKS, 8'h04, 0, 33'h0);
    od(1, `PCE_IDX_ANA_GATE, 8'h00, 1, 33'h0);
    od(0, `PCE_IDX_ANA_GATE, 8'h00, 0, 33'h1);
    od(1, `PCE_IDX_ANA_GATE, 8'h01, 1, 33'h1_0000_0000);
    put(1, 64'h200);
    expect_none();
    pdo_upper_limit[1] <= 64'h800;
    expect_tx({4'h1, 64'h200});
    put(1, 64'h900);
    expect_tx({4'h1, 64'h900});
    pdo_upper_limit[1] <= 64'h0;
    pdo_lo_delta_on[1] <= 1'b1;
    put(1, 64'h901);
    expect_tx({4'h1, 64'h901});
    pdo_upper_limit[1] <= 64'h800;
    expect_tx({4'h1, 64'h901});
    pdo_upper_limit[1] <= 64'h0;
    pdo_lo_delta_on[1] <= 1'b0;
    put(1, 64'h902);
    expect_none();
  endtask : t_analog
  // sixteen queued plus one held back by the stalled scan
  task automatic t_fill;
    stall <= 1'b1;
    repeat (2) @(posedge clk_sys);
    for (int i = 1; i <= 20; i++) begin
      put(0, 64'h4000 + i);
      repeat (2) @(posedge clk_sys);
    end
    `CHK(tx_valid, 1'b1)
    stall <= 1'b0;
    repeat (60) @(posedge clk_sys);
    `CHK(u_pce_master_model.got.size(), 17)
    `CHK(u_pce_master_model.got[16].data, 64'h4014)
    u_pce_master_model.got.delete();
  endtask : t_fill
  task automatic t_reset;
    od(1, `PCE_IDX_MASKS, 8'h01, 0, 33'h0);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    `CHK(dig_out, 16'h0)
    od(0, `PCE_IDX_MASKS, 8'h01, 0, 33'hffff_ffff);
    od(0, `PCE_IDX_ANA_GATE, 8'h00, 0, 33'h0);
  endtask : t_reset
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_regs();
    t_mask();
    t_ttype();
    t_analog();
    t_fill();
    t_reset();
    report_and_stop();
  end
endmodule : pce_top_bench
